/* hdl/pp_pkg.sv */
// constants, register map and types for the power path selector
package pp_pkg;

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h01;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h02;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h03;

  // ------------------------------------------------------------------
  // charger_config_reg fields
  // ------------------------------------------------------------------
  localparam int CFG_CE        = 0;
  localparam int CFG_CHARGE_ON = 1;
  localparam int CFG_MID_SEL   = 2;
  localparam int CFG_LIMIT_HI  = 3;
  localparam int CFG_W         = 4;
  // charger disabled, usb limit 500 mA
  localparam logic [3:0] CONFIG_RESET = 4'h4;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // ------------------------------------------------------------------
  // path_status_reg fields
  // ------------------------------------------------------------------
  localparam int ST_AC_SW     = 0;
  localparam int ST_USB_SW    = 1;
  localparam int ST_BAT_SW    = 2;
  localparam int ST_AC_DET    = 3;
  localparam int ST_USB_DET   = 4;
  localparam int ST_AC_OVP    = 5;
  localparam int ST_USB_OVP   = 6;
  localparam int ST_SUPPLEMENT = 7;

  // ------------------------------------------------------------------
  // interrupt status / mask fields
  // ------------------------------------------------------------------
  localparam int EV_AC_DET    = 0;
  localparam int EV_USB_DET   = 1;
  localparam int EV_AC_OVP    = 2;
  localparam int EV_USB_OVP   = 3;
  localparam int EV_SOURCE    = 4;
  localparam int EV_OUT_SHORT = 5;
  localparam int EV_BAT_SHORT = 6;
  localparam int EV_THERMAL   = 7;
  localparam int EV_W         = 8;

  // ------------------------------------------------------------------
  // comparator input vector positions
  // ------------------------------------------------------------------
  localparam int IN_AC_DET    = 0;
  localparam int IN_USB_DET   = 1;
  localparam int IN_AC_OVP    = 2;
  localparam int IN_USB_OVP   = 3;
  localparam int IN_OUT_SHORT = 4;
  localparam int IN_BAT_SHORT = 5;
  localparam int IN_SUPPLEMENT = 6;
  localparam int IN_DPM_LOW   = 7;
  localparam int IN_THERMAL   = 8;
  localparam int IN_W         = 9;

  // ------------------------------------------------------------------
  // input current limit codes
  // ------------------------------------------------------------------
  localparam logic [1:0] LIMIT_100MA  = 2'h0;
  localparam logic [1:0] LIMIT_500MA  = 2'h1;
  localparam logic [1:0] LIMIT_2750MA = 2'h2;

  typedef enum logic [2:0] {
    PATH_BATTERY,
    PATH_AC,
    PATH_USB,
    PATH_FORCED_BATTERY,
    PATH_THERMAL,
    PATH_OUT_SHORT
  } path_t;

endpackage

/* hdl/sync_2ff.sv */
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module sync_2ff
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import pp_pkg::*;

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_meta = meta;
    next_q    = q;
    if (!rst_n)
    begin
      next_meta = '0;
      next_q    = '0;
    end
    else if (ce)
    begin
      next_meta = d;
      next_q    = meta;
    end
  end

  always_ff @(posedge clk)
  begin
    meta <= next_meta;
    q    <= next_q;
  end

endmodule // sync_2ff

/* hdl/event_flags.sv */
// sticky event flags, write one to clear, set wins over clear
`timescale 1ns/1ps
module event_flags
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clear,
  output logic      [WIDTH-1:0] flags
);
  import pp_pkg::*;

  logic [WIDTH-1:0] next_flags;

  always_comb
  begin
    next_flags = flags;
    if (!rst_n)
      next_flags = '0;
    else if (ce)
      next_flags = (flags & ~clear) | set;
  end

  always_ff @(posedge clk)
  begin
    flags <= next_flags;
  end

endmodule // event_flags

/* hdl/power_path_source_selector.sv */
// power path source selection, switch control and host registers
//
// Operation
// - flag ac and usb present from comparators
// - charger enabled: ac, then usb, then battery
// - usb source: battery switch follows supplement need
// - lost input falls back to next source
// - charger disabled: inputs open, battery closed
// - override never reconnects inputs on battery removal
// - power path state readable in status register
// - two host bits pick usb current limit
// - ac limit always fixed short-circuit value
// - input overvoltage sets readable status bit
// - overvoltage leaves input switches unchanged
// - thermal shutdown: inputs open, battery closed
// - output short: inputs open, input pull-ups on
// - output short cleared: normal selection resumes
// - battery short: battery open, pull-up on
// - battery short blanked while dpm level low
// - supplement need steers battery switch selection
// - reset values: charger off, usb 500 mA
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module power_path_source_selector
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  // comparator results
  input  wire logic                        ac_detect,
  input  wire logic                        usb_detect,
  input  wire logic                        ac_overvoltage,
  input  wire logic                        usb_overvoltage,
  input  wire logic                        output_short,
  input  wire logic                        battery_short,
  input  wire logic                        supplement_need,
  input  wire logic                        dynamic_power_mgmt_low,
  input  wire logic                        thermal_shutdown,
  // register port
  input  wire logic [pp_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [pp_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [pp_pkg::DATA_W-1:0]   reg_rdata,
  // power path controls
  output logic                             ac_switch_en,
  output logic                             usb_switch_en,
  output logic                             bat_switch_en,
  output logic                             ac_pullup_en,
  output logic                             usb_pullup_en,
  output logic                             bat_pullup_en,
  output logic      [1:0]                  usb_limit_code,
  output logic      [1:0]                  ac_limit_code,
  output logic                             charger_run,
  output logic                             irq
);
  import pp_pkg::*;

  // ------------------------------------------------------------------
  // comparator synchronisation
  // ------------------------------------------------------------------
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sin;

  always_comb
  begin
    raw_in                = '0;
    raw_in[IN_AC_DET]     = ac_detect;
    raw_in[IN_USB_DET]    = usb_detect;
    raw_in[IN_AC_OVP]     = ac_overvoltage;
    raw_in[IN_USB_OVP]    = usb_overvoltage;
    raw_in[IN_OUT_SHORT]  = output_short;
    raw_in[IN_BAT_SHORT]  = battery_short;
    raw_in[IN_SUPPLEMENT] = supplement_need;
    raw_in[IN_DPM_LOW]    = dynamic_power_mgmt_low;
    raw_in[IN_THERMAL]    = thermal_shutdown;
  end

  sync_2ff
  #(
    .WIDTH (IN_W)
  )
  u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (raw_in),
    .q     (sin)
  );

  logic ac_present;
  logic usb_present;
  logic bat_short_live;

  assign ac_present     = sin[IN_AC_DET];
  assign usb_present    = sin[IN_USB_DET];
  // blanked while the dpm pin sits low
  assign bat_short_live = sin[IN_BAT_SHORT]
                          & ~sin[IN_DPM_LOW];

  // ------------------------------------------------------------------
  // host configuration registers
  // ------------------------------------------------------------------
  logic [CFG_W-1:0]  config_bits;
  logic [CFG_W-1:0]  next_config_bits;
  logic [EV_W-1:0]   irq_mask;
  logic [EV_W-1:0]   next_irq_mask;
  logic              wr_config;
  logic              wr_mask;
  logic              wr_irq;

  assign wr_config = reg_write && (reg_addr == OFS_CONFIG);
  assign wr_mask   = reg_write && (reg_addr == OFS_IRQ_MASK);
  assign wr_irq    = reg_write && (reg_addr == OFS_IRQ_STATUS);

  always_comb
  begin
    next_config_bits = config_bits;
    next_irq_mask    = irq_mask;
    if (!rst_n)
    begin
      next_config_bits = CONFIG_RESET;
      next_irq_mask    = IRQ_MASK_RESET;
    end
    else if (ce)
    begin
      if (wr_config)
        next_config_bits = reg_wdata[CFG_W-1:0];
      if (wr_mask)
        next_irq_mask = reg_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    config_bits <= next_config_bits;
    irq_mask    <= next_irq_mask;
  end

  // ------------------------------------------------------------------
  // source selection and switch control
  // ------------------------------------------------------------------
  path_t       path;
  path_t       next_path;
  logic        next_ac_sw;
  logic        next_usb_sw;
  logic        next_bat_sw;
  logic        next_ac_pu;
  logic        next_usb_pu;
  logic        next_bat_pu;
  logic [1:0]  next_usb_limit;
  logic [1:0]  next_ac_limit;
  logic        next_charger_run;
  path_t       sel_path;

  // selection from current inputs; ovp is deliberately not a term
  always_comb
  begin
    if (sin[IN_THERMAL])
      sel_path = PATH_THERMAL;
    else if (sin[IN_OUT_SHORT])
      sel_path = PATH_OUT_SHORT;
    else if (!config_bits[CFG_CE])
      sel_path = PATH_FORCED_BATTERY;
    else if (ac_present)
      sel_path = PATH_AC;
    else if (usb_present)
      sel_path = PATH_USB;
    else
      sel_path = PATH_BATTERY;
  end

  always_comb
  begin
    next_path        = path;
    next_ac_sw       = ac_switch_en;
    next_usb_sw      = usb_switch_en;
    next_bat_sw      = bat_switch_en;
    next_ac_pu       = ac_pullup_en;
    next_usb_pu      = usb_pullup_en;
    next_bat_pu      = bat_pullup_en;
    next_usb_limit   = usb_limit_code;
    next_ac_limit    = ac_limit_code;
    next_charger_run = charger_run;
    if (!rst_n)
    begin
      next_path        = PATH_FORCED_BATTERY;
      next_ac_sw       = 1'b0;
      next_usb_sw      = 1'b0;
      next_bat_sw      = 1'b1;
      next_ac_pu       = 1'b0;
      next_usb_pu      = 1'b0;
      next_bat_pu      = 1'b0;
      next_usb_limit   = LIMIT_500MA;
      next_ac_limit    = LIMIT_2750MA;
      next_charger_run = 1'b0;
    end
    else if (ce)
    begin
      next_path   = sel_path;
      next_ac_sw  = 1'b0;
      next_usb_sw = 1'b0;
      next_bat_sw = 1'b0;
      next_ac_pu  = 1'b0;
      next_usb_pu = 1'b0;
      next_bat_pu = 1'b0;
      unique case (sel_path)
        PATH_AC:
        begin
          next_ac_sw  = 1'b1;
          next_bat_sw = sin[IN_SUPPLEMENT];
        end
        PATH_USB:
        begin
          next_usb_sw = 1'b1;
          next_bat_sw = sin[IN_SUPPLEMENT];
        end
        PATH_OUT_SHORT:
        begin
          next_ac_pu  = 1'b1;
          next_usb_pu = 1'b1;
          next_bat_sw = 1'b1;
        end
        PATH_BATTERY, PATH_FORCED_BATTERY, PATH_THERMAL:
        begin
          next_bat_sw = 1'b1;
        end
      endcase
      if (bat_short_live)
      begin
        next_bat_sw = 1'b0;
        next_bat_pu = 1'b1;
      end
      if (config_bits[CFG_LIMIT_HI])
        next_usb_limit = LIMIT_2750MA;
      else if (config_bits[CFG_MID_SEL])
        next_usb_limit = LIMIT_500MA;
      else
        next_usb_limit = LIMIT_100MA;
      next_ac_limit    = LIMIT_2750MA;
      next_charger_run = config_bits[CFG_CE]
                         & config_bits[CFG_CHARGE_ON];
    end
  end

  always_ff @(posedge clk)
  begin
    path           <= next_path;
    ac_switch_en   <= next_ac_sw;
    usb_switch_en  <= next_usb_sw;
    bat_switch_en  <= next_bat_sw;
    ac_pullup_en   <= next_ac_pu;
    usb_pullup_en  <= next_usb_pu;
    bat_pullup_en  <= next_bat_pu;
    usb_limit_code <= next_usb_limit;
    ac_limit_code  <= next_ac_limit;
    charger_run    <= next_charger_run;
  end

  // ------------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------------
  logic [IN_W-1:0] prev_in;
  logic [IN_W-1:0] next_prev_in;
  logic            prev_bat_short;
  logic            next_prev_bat_short;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irq_flags;
  logic [EV_W-1:0] irq_clear;
  logic            src_change;

  assign src_change = ((path == PATH_AC) && (sel_path == PATH_USB))
                   || ((path == PATH_USB) && (sel_path == PATH_AC));

  always_comb
  begin
    events               = '0;
    events[EV_AC_DET]    = sin[IN_AC_DET] ^ prev_in[IN_AC_DET];
    events[EV_USB_DET]   = sin[IN_USB_DET] ^ prev_in[IN_USB_DET];
    events[EV_AC_OVP]    = sin[IN_AC_OVP]
                           & ~prev_in[IN_AC_OVP];
    events[EV_USB_OVP]   = sin[IN_USB_OVP]
                           & ~prev_in[IN_USB_OVP];
    events[EV_SOURCE]    = src_change;
    events[EV_OUT_SHORT] = sin[IN_OUT_SHORT] & ~prev_in[IN_OUT_SHORT];
    events[EV_BAT_SHORT] = bat_short_live & ~prev_bat_short;
    events[EV_THERMAL]   = sin[IN_THERMAL] & ~prev_in[IN_THERMAL];
    if (!ce)
      events = '0;
  end

  always_comb
  begin
    next_prev_in        = prev_in;
    next_prev_bat_short = prev_bat_short;
    if (!rst_n)
    begin
      next_prev_in        = '0;
      next_prev_bat_short = 1'b0;
    end
    else if (ce)
    begin
      next_prev_in        = sin;
      next_prev_bat_short = bat_short_live;
    end
  end

  always_ff @(posedge clk)
  begin
    prev_in        <= next_prev_in;
    prev_bat_short <= next_prev_bat_short;
  end

  assign irq_clear = wr_irq ? reg_wdata[EV_W-1:0] : '0;

  event_flags
  #(
    .WIDTH (EV_W)
  )
  u_flags
  (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .set   (events),
    .clear (irq_clear),
    .flags (irq_flags)
  );

  assign irq = |(irq_flags & irq_mask);

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] next_rdata;

  always_comb
  begin
    status_word                = '0;
    status_word[ST_AC_SW]      = ac_switch_en;
    status_word[ST_USB_SW]     = usb_switch_en;
    status_word[ST_BAT_SW]     = bat_switch_en;
    status_word[ST_AC_DET]     = ac_present;
    status_word[ST_USB_DET]    = usb_present;
    status_word[ST_AC_OVP]     = sin[IN_AC_OVP];
    status_word[ST_USB_OVP]    = sin[IN_USB_OVP];
    status_word[ST_SUPPLEMENT] = sin[IN_SUPPLEMENT];
  end

  always_comb
  begin
    next_rdata = '0;
    if (rst_n && ce && reg_read)
    begin
      unique case (reg_addr)
        OFS_CONFIG:     next_rdata = {4'h0, config_bits};
        OFS_STATUS:     next_rdata = status_word;
        OFS_IRQ_STATUS: next_rdata = irq_flags;
        OFS_IRQ_MASK:   next_rdata = irq_mask;
        default:        next_rdata = '0;
      endcase
    end
    else if (rst_n && !ce)
      next_rdata = reg_rdata;
  end

  always_ff @(posedge clk)
  begin
    reg_rdata <= next_rdata;
  end

endmodule // power_path_source_selector

/* sim/pp_far_side.sv */
// far side model: adapter, usb port and battery pack
`timescale 1ns/1ps
module pp_far_side
(
  input  wire logic ac_on,
  input  wire logic usb_on,
  input  wire logic ac_hv,
  input  wire logic usb_hv,
  input  wire logic out_sc,
  input  wire logic bat_sc,
  input  wire logic bat_in,
  input  wire logic load_hi,
  input  wire logic dpm_lo,
  input  wire logic hot,
  input  wire logic ac_switch_en,
  input  wire logic usb_switch_en,
  output logic      ac_detect,
  output logic      usb_detect,
  output logic      ac_overvoltage,
  output logic      usb_overvoltage,
  output logic      output_short,
  output logic      battery_short,
  output logic      supplement_need,
  output logic      dynamic_power_mgmt_low,
  output logic      thermal_shutdown
);
  assign ac_detect              = ac_on;
  assign usb_detect             = usb_on;
  assign ac_overvoltage         = ac_hv;
  assign usb_overvoltage        = usb_hv;
  assign output_short           = out_sc;
  assign battery_short          = bat_sc & bat_in;
  // bus sags below battery only while an input feeds it
  assign supplement_need        = load_hi & bat_in &
                                  (ac_switch_en | usb_switch_en);
  assign dynamic_power_mgmt_low = dpm_lo;
  assign thermal_shutdown       = hot;
endmodule // pp_far_side

/* sim/pp_properties.sv */
// assertion checker on the power path selector ports
`timescale 1ns/1ps
module pp_properties
(
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      ce,
  input wire logic                      ac_detect,
  input wire logic                      usb_detect,
  input wire logic                      ac_overvoltage,
  input wire logic                      usb_overvoltage,
  input wire logic                      output_short,
  input wire logic                      battery_short,
  input wire logic                      supplement_need,
  input wire logic                      dynamic_power_mgmt_low,
  input wire logic                      thermal_shutdown,
  input wire logic [pp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                      reg_write,
  input wire logic                      reg_read,
  input wire logic [pp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                      ac_switch_en,
  input wire logic                      usb_switch_en,
  input wire logic                      bat_switch_en,
  input wire logic                      ac_pullup_en,
  input wire logic                      usb_pullup_en,
  input wire logic                      bat_pullup_en,
  input wire logic [1:0]                usb_limit_code,
  input wire logic [1:0]                ac_limit_code,
  input wire logic                      charger_run,
  input wire logic                      irq
);
  import pp_pkg::*;
  logic [2:0] settle_cnt;
  logic [2:0] next_settle_cnt;
  logic       settled;
  // ------------------------------------------------------------
  // cycles since reset, synchroniser flushed after four
  // ------------------------------------------------------------
  assign settled = settle_cnt == 3'h4;
  always_comb next_settle_cnt = settled ? settle_cnt : settle_cnt + 3'h1;
  always_ff @(posedge clk) settle_cnt <= rst_n ? next_settle_cnt : 3'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_thermal_opens_inputs: assert property (
    (settled && thermal_shutdown && !battery_short) [*3] |=>
      !ac_switch_en && !usb_switch_en && bat_switch_en)
    else $error("thermal shutdown left inputs closed");
  a_short_pullups_on: assert property (
    (settled && output_short && !thermal_shutdown) [*3] |=>
      !ac_switch_en && !usb_switch_en && ac_pullup_en && usb_pullup_en)
    else $error("output short not handled");
  a_short_recovery_ends: assert property (
    (settled && !output_short) [*4] |=> !ac_pullup_en && !usb_pullup_en)
    else $error("input pull-ups stayed on");
  a_bat_short_opens: assert property (
    (settled && battery_short && !dynamic_power_mgmt_low) [*3] |=>
      !bat_switch_en && bat_pullup_en)
    else $error("battery short not handled");
  a_bat_short_blank: assert property (
    (settled && dynamic_power_mgmt_low) [*3] |=> !bat_pullup_en)
    else $error("battery short acted while blanked");
  a_one_input_only: assert property (
    !(ac_switch_en && usb_switch_en))
    else $error("both input switches closed");
  a_ac_limit_fixed: assert property (
    ac_limit_code == LIMIT_2750MA)
    else $error("ac limit not fixed");
  a_limit_follows_write: assert property (
    reg_write && reg_addr == OFS_CONFIG |=> ##1 usb_limit_code ==
      ($past(reg_wdata[CFG_LIMIT_HI], 2) ? LIMIT_2750MA :
       $past(reg_wdata[CFG_MID_SEL], 2) ? LIMIT_500MA : LIMIT_100MA))
    else $error("usb limit code wrong after write");
  a_disable_opens_inputs: assert property (
    reg_write && reg_addr == OFS_CONFIG && !reg_wdata[CFG_CE] |=>
      ##1 !ac_switch_en && !usb_switch_en)
    else $error("input switch closed with charger disabled");
endmodule // pp_properties

bind power_path_source_selector pp_properties u_props (.*);

/* sim/tb.sv */
// self-checking bench for the power path selector
`timescale 1ns/1ps
module tb;
  import pp_pkg::*;
  logic       clk, rst_n, ce, irq, charger_run;
  logic       ac_on, usb_on, ac_hv, usb_hv, out_sc, bat_sc;
  logic       bat_in, load_hi, dpm_lo, hot;
  logic       ac_detect, usb_detect, ac_overvoltage, usb_overvoltage;
  logic       output_short, battery_short, supplement_need;
  logic       dynamic_power_mgmt_low, thermal_shutdown;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_write, reg_read;
  logic       ac_switch_en, usb_switch_en, bat_switch_en;
  logic       ac_pullup_en, usb_pullup_en, bat_pullup_en;
  logic [1:0] usb_limit_code, ac_limit_code;
  int         fails, samples_checked;

  pp_far_side far (.*);
  power_path_source_selector dut (.*);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------------------------------------
  // bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [7:0] sws();
    return {5'h00, bat_switch_en, usb_switch_en, ac_switch_en};
  endfunction
  function automatic logic [7:0] pus();
    return {5'h00, bat_pullup_en, usb_pullup_en, ac_pullup_en};
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    @(negedge clk);
    chk("switches", 8'h04, sws());
    chk("usb limit", 8'h01, {6'h00, usb_limit_code});
    chk("charger run", 8'h00, {7'h00, charger_run});
    rd(OFS_CONFIG, d);
    chk("config", 8'h04, d);
    rd(8'h10, d);
    chk("unmapped", 8'h00, d);
  endtask
  task automatic t_priority;
    logic [7:0] d;
    logic [2:0] e;
    wr(OFS_CONFIG, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ac_on  <= i[1];
      usb_on <= i[0];
      settle();
      e = i[1] ? 3'h1 : i[0] ? 3'h2 : 3'h4;
      chk("source", {5'h00, e}, sws());
      rd(OFS_STATUS, d);
      chk("status", {3'h0, i[0], i[1], e}, d);
    end
    @(posedge clk);
    ac_on <= 1'b0;
    settle();
    chk("fallback usb", 8'h02, sws());
    @(posedge clk);
    load_hi <= 1'b1;
    settle();
    chk("supplement", 8'h06, sws());
    rd(OFS_STATUS, d);
    chk("status", 8'h96, d);
    @(posedge clk);
    load_hi <= 1'b0;
    usb_on  <= 1'b0;
    settle();
    chk("fallback battery", 8'h04, sws());
  endtask
  task automatic t_disable;
    @(posedge clk);
    ac_on  <= 1'b1;
    usb_on <= 1'b1;
    wr(OFS_CONFIG, 8'h04);
    settle();
    chk("disabled", 8'h04, sws());
    @(posedge clk);
    bat_in <= 1'b0;
    settle();
    chk("battery removed", 8'h04, sws());
    @(posedge clk);
    bat_in <= 1'b1;
    ac_on  <= 1'b0;
  endtask
  task automatic t_limits;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CONFIG, {4'h0, i[1:0], 2'h1});
      settle();
      chk("usb limit", i[1] ? 8'h02 : {7'h00, i[0]},
          {6'h00, usb_limit_code});
      chk("ac limit", 8'h02, {6'h00, ac_limit_code});
    end
    wr(OFS_CONFIG, 8'h07);
    settle();
    chk("charger run", 8'h01, {7'h00, charger_run});
    chk("usb limit", 8'h01, {6'h00, usb_limit_code});
  endtask
  task automatic t_overvoltage;
    logic [7:0] d;
    wr(OFS_CONFIG, 8'h05);
    wr(OFS_IRQ_MASK, 8'h0C);
    wr(OFS_IRQ_STATUS, 8'hFF);
    @(negedge clk);
    chk("irq idle", 8'h00, {7'h00, irq});
    @(posedge clk);
    ac_hv  <= 1'b1;
    usb_hv <= 1'b1;
    settle();
    chk("switches kept", 8'h02, sws());
    rd(OFS_STATUS, d);
    chk("ovp status", 8'h72, d);
    chk("irq raised", 8'h01, {7'h00, irq});
    rd(OFS_IRQ_STATUS, d);
    chk("irq flags", 8'h0C, d);
    rd(OFS_IRQ_MASK, d);
    chk("irq mask", 8'h0C, d);
    wr(OFS_IRQ_STATUS, 8'h0C);
    @(negedge clk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    @(posedge clk);
    ac_hv  <= 1'b0;
    usb_hv <= 1'b0;
  endtask
  task automatic t_faults;
    @(posedge clk);
    hot <= 1'b1;
    settle();
    chk("thermal", 8'h04, sws());
    @(posedge clk);
    hot    <= 1'b0;
    out_sc <= 1'b1;
    settle();
    chk("short switches", 8'h04, sws());
    chk("short pullups", 8'h03, pus());
    @(posedge clk);
    out_sc <= 1'b0;
    settle();
    chk("recovered", 8'h02, sws());
    chk("pullups off", 8'h00, pus());
    @(posedge clk);
    usb_on <= 1'b0;
    bat_sc <= 1'b1;
    settle();
    chk("bat short", 8'h00, sws());
    chk("bat pullup", 8'h04, pus());
    @(posedge clk);
    dpm_lo <= 1'b1;
    settle();
    chk("blanked", 8'h04, sws());
    chk("blanked pullup", 8'h00, pus());
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    {ac_on, usb_on, ac_hv, usb_hv, out_sc, bat_sc} = 6'h00;
    {load_hi, dpm_lo, hot, reg_write, reg_read} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    bat_in = 1'b1;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_priority();
    t_disable();
    t_limits();
    t_overvoltage();
    t_faults();
    summarize();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule // tb
